// file: logic/ltl_pkg.sv
/*
  Package for the layer-1 control block: widths, state enums, carriers and counts.
  Assumes a single system clock at 25 MHz and a serial control port clocked by the host.
*/
package ltl_pkg;

  localparam int unsigned SYS_CLK_HZ       = 25000000;
  localparam int unsigned REG_WIDTH        = 8;
  localparam int unsigned XTAL_RESET_MIN   = 40;
  localparam int unsigned XTAL_RELEASE_MIN = 10;
  localparam int unsigned XTAL_SEQ_TOTAL   = XTAL_RESET_MIN + XTAL_RELEASE_MIN;
  localparam int unsigned WAKE_FRAMES      = 6;
  localparam int unsigned LINE_RATE_BPS    = 384000;
  localparam int unsigned FRAME_CLK_HZ     = 1536000;
  localparam int unsigned LINE_DIV         = FRAME_CLK_HZ / LINE_RATE_BPS;
  localparam int unsigned AUX_DIV          = 16;
  localparam int unsigned FRAME_LEN        = 32;
  localparam int unsigned LEVEL_TIMEOUT_MS = 110;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;

  localparam int unsigned ST_SYNC_BIT      = 0;
  localparam int unsigned ST_ACTIVE_BIT    = 1;
  localparam int unsigned ST_SYNC_L2_BIT   = 2;
  localparam int unsigned ST_ACTIVE_L2_BIT = 3;
  localparam int unsigned ST_LEVEL_BIT     = 4;
  localparam int unsigned ST_DEACT_BIT     = 5;

  typedef enum logic [1:0] {
    LTL_MODE_ENDPOINT,
    LTL_MODE_REPEATER,
    LTL_MODE_HDLC
  } ltl_mode_t;

  typedef enum {
    LTL_PWR_RESET,
    LTL_PWR_TAIL,
    LTL_PWR_FRAMES,
    LTL_PWR_DEACT,
    LTL_PWR_RUN
  } ltl_pwr_t;

  typedef struct packed {
    logic signal_seen;
    logic bit_sync;
    logic activated;
    logic service_bit;
  } ltl_line_t;

  typedef struct packed {
    logic sync_reached_ind;
    logic line_active_ind;
    logic sync_reached_loop2_ind;
    logic line_active_loop2_ind;
    logic level_detect;
    logic deactivated;
  } ltl_ind_t;

endpackage : ltl_pkg

// file: logic/ltl_serial_port.sv
/*
  Serial control port slave: shifts the first status register out on MISO and
  takes the first control register in from MOSI, both most significant bit first.
  Assumes sclk, cs_n and mosi are already synchronised to sys_clk.
*/
`timescale 1ns/10ps
module ltl_serial_port
  import ltl_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 cs_n,
  input  wire logic                 sclk,
  input  wire logic                 mosi,
  input  wire logic [REG_WIDTH-1:0] status_in,
  output logic                      miso,
  output logic [REG_WIDTH-1:0]      first_control_reg,
  output logic                      ctrl_written
);

  logic                 sclk_d;
  logic [REG_WIDTH-1:0] shift_out;
  logic [REG_WIDTH-1:0] shift_in;
  logic [3:0]           bit_cnt;
  logic                 fall;
  logic                 rise;

  assign fall = sclk_d & ~sclk;
  assign rise = ~sclk_d & sclk;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk;
    end
  end

  // Status snapshot at first fall keeps the word coherent during the shift
  always_ff @(posedge sys_clk) begin
    if (!rst_n || cs_n) begin
      shift_out <= '0;
      miso      <= 1'b0;
    end else if (fall && bit_cnt == 4'h0) begin
      shift_out <= {status_in[REG_WIDTH-2:0], 1'b0};
      miso      <= status_in[REG_WIDTH-1];
    end else if (fall) begin
      shift_out <= {shift_out[REG_WIDTH-2:0], 1'b0};
      miso      <= shift_out[REG_WIDTH-1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || cs_n) begin
      bit_cnt  <= 4'h0;
      shift_in <= '0;
    end else if (rise && bit_cnt < 4'(REG_WIDTH)) begin
      bit_cnt  <= bit_cnt + 4'h1;
      shift_in <= {shift_in[REG_WIDTH-2:0], mosi};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      first_control_reg <= CTRL_RESET;
      ctrl_written      <= 1'b0;
    end else begin
      ctrl_written <= 1'b0;
      if (!cs_n && rise && bit_cnt == 4'(REG_WIDTH - 1)) begin
        first_control_reg <= {shift_in[REG_WIDTH-2:0], mosi};
        ctrl_written      <= 1'b1;
      end
    end
  end

endmodule : ltl_serial_port

// file: logic/ltl_layer1_control.sv
/*
  Layer-1 control top: power-up reset sequence, line rate and auxiliary dividers,
  line state indications and the serial control port.
  Assumes crystal_clock_in, the frame-bus clock and all pin inputs are asynchronous
  to sys_clk and much slower than it; each except mode and restart_activation_cmd passes two flip-flops before use.
*/
`timescale 1ns/10ps
// How it works
// - Repeater mode: line rate divided from frame clock
// - Endpoint mode: timing from plain crystal dividers
// - HDLC mode: reset pin pulse resets device
// - After 50 pulses, 6 frames, then deactivated
// - Signal seen, no bit sync: level detect
// - Loop 2 follows the normal endpoint states
// - Service bit one selects loop-2 indications
// - First falling clock loads status, drives MSB
// - Later clocks shift remaining status bits out
// - Control taken on last period rising edge
module ltl_layer1_control
  import ltl_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire ltl_mode_t       mode,
  input  wire logic            reset_pin_n,
  input  wire logic            crystal_clock_in,
  input  wire logic            frame_clk_in,
  input  wire ltl_line_t       line_in,
  input  wire logic            restart_activation_cmd,
  input  wire logic            cs_n,
  input  wire logic            sclk,
  input  wire logic            mosi,
  output logic                 miso,
  output logic                 line_bit_clk,
  output logic                 aux_clk,
  output logic                 frame_sync,
  output logic                 device_reset,
  output ltl_ind_t             indications,
  output logic [REG_WIDTH-1:0] first_control_reg
);

  logic [1:0] xtal_sync;
  logic [1:0] frm_sync;
  logic [1:0] rstp_sync;
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] mosi_sync;
  logic [3:0] line_sync [2];
  logic       xtal_d;
  logic       frm_d;
  logic       xtal_rise;
  logic       frm_rise;
  logic       reset_active;
  ltl_line_t  line_s;

  ltl_pwr_t   pwr;
  logic [5:0] xtal_cnt;
  logic [2:0] frame_cnt;
  logic [4:0] frame_pos;
  logic       powered_up;
  logic [1:0] line_div_cnt;
  logic [3:0] aux_div_cnt;
  logic [REG_WIDTH-1:0] status_word;
  logic [REG_WIDTH-1:0] ctrl_value;
  logic       ctrl_written;
  logic       spi_miso;

  // Two stages on every pin except mode and restart_activation_cmd; first stage read only by the second
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      xtal_sync <= 2'h0;
      frm_sync  <= 2'h0;
      rstp_sync <= 2'h3;
      cs_sync   <= 2'h3;
      sclk_sync <= 2'h3;
      mosi_sync <= 2'h0;
      line_sync[0] <= 4'h0;
      line_sync[1] <= 4'h0;
    end else begin
      xtal_sync <= {xtal_sync[0], crystal_clock_in};
      frm_sync  <= {frm_sync[0], frame_clk_in};
      rstp_sync <= {rstp_sync[0], reset_pin_n};
      cs_sync   <= {cs_sync[0], cs_n};
      sclk_sync <= {sclk_sync[0], sclk};
      mosi_sync <= {mosi_sync[0], mosi};
      line_sync[0] <= line_in;
      line_sync[1] <= line_sync[0];
    end
  end

  assign line_s       = ltl_line_t'(line_sync[1]);
  assign xtal_rise    = xtal_sync[1] & ~xtal_d;
  assign frm_rise     = frm_sync[1] & ~frm_d;
  assign reset_active = ~rstp_sync[1];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      xtal_d <= 1'b0;
      frm_d  <= 1'b0;
    end else begin
      xtal_d <= xtal_sync[1];
      frm_d  <= frm_sync[1];
    end
  end

  // Reset pin acts in every mode; HDLC configuration relies on it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      device_reset <= 1'b1;
    end else begin
      device_reset <= reset_active;
    end
  end

  // Power-up sequence counted on crystal edges; host supplies the pulses
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwr        <= LTL_PWR_RESET;
      xtal_cnt   <= 6'h00;
      frame_cnt  <= 3'h0;
      powered_up <= 1'b0;
    end else begin
      unique case (pwr)
        LTL_PWR_RESET: begin
          if (xtal_rise && reset_active && xtal_cnt < 6'(XTAL_RESET_MIN)) begin
            xtal_cnt <= xtal_cnt + 6'h01;
          end
          if (!reset_active) begin
            if (powered_up) begin
              pwr <= LTL_PWR_RUN;
            end else if (xtal_cnt >= 6'(XTAL_RESET_MIN)) begin
              pwr <= LTL_PWR_TAIL;
            end else begin
              xtal_cnt <= 6'h00;
            end
          end
        end
        LTL_PWR_TAIL: begin
          if (reset_active) begin
            pwr      <= LTL_PWR_RESET;
            xtal_cnt <= 6'(XTAL_RESET_MIN); // Re-entry must still see ten tail pulses
          end else if (xtal_rise) begin
            xtal_cnt <= xtal_cnt + 6'h01;
            if (xtal_cnt == 6'(XTAL_SEQ_TOTAL - 1)) begin
              pwr       <= LTL_PWR_FRAMES;
              frame_cnt <= 3'h0;
            end
          end
        end
        LTL_PWR_FRAMES: begin
          if (reset_active) begin
            pwr      <= LTL_PWR_RESET;
            xtal_cnt <= 6'(XTAL_RESET_MIN); // A count past the tail end would have to wrap before the tail could end
          end else if (frame_sync && frame_cnt == 3'(WAKE_FRAMES - 1)) begin
            pwr        <= LTL_PWR_DEACT;
            powered_up <= 1'b1;
          end else if (frame_sync) begin
            frame_cnt <= frame_cnt + 3'h1;
          end
        end
        LTL_PWR_DEACT: begin
          if (reset_active) begin
            pwr <= LTL_PWR_RESET;
          end else if (line_s.signal_seen) begin
            pwr <= LTL_PWR_RUN;
          end
        end
        LTL_PWR_RUN: begin
          if (reset_active) begin
            pwr <= LTL_PWR_RESET;
          end else if (restart_activation_cmd) begin
            pwr <= LTL_PWR_DEACT;
          end
        end
      endcase
    end
  end

  // Frame marker from frame-bus clock; one pulse per frame
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frame_pos  <= 5'h00;
      frame_sync <= 1'b0;
    end else begin
      frame_sync <= 1'b0;
      if (frm_rise) begin
        frame_pos <= frame_pos + 5'h01;
        if (frame_pos == 5'(FRAME_LEN - 1)) begin
          frame_sync <= 1'b1;
        end
      end
    end
  end

  // Line and aux clocks; repeater locks the line clock to frame clock, aux always from crystal
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      line_div_cnt <= 2'h0;
      aux_div_cnt  <= 4'h0;
      line_bit_clk <= 1'b0;
      aux_clk      <= 1'b0;
    end else begin
      if (mode == LTL_MODE_REPEATER ? frm_rise : xtal_rise) begin
        line_div_cnt <= line_div_cnt + 2'h1;
        if (line_div_cnt == 2'(LINE_DIV / 2 - 1) || line_div_cnt == 2'(LINE_DIV - 1)) begin
          line_bit_clk <= ~line_bit_clk;
        end
      end
      if (xtal_rise) begin
        aux_div_cnt <= aux_div_cnt + 4'h1;
        if (aux_div_cnt == 4'(AUX_DIV / 2 - 1) || aux_div_cnt == 4'(AUX_DIV - 1)) begin
          aux_clk <= ~aux_clk;
        end
      end
    end
  end

  // Loop 2 shares endpoint states; only the reported code changes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      indications <= '0;
    end else begin
      indications.deactivated  <= (pwr != LTL_PWR_RUN);
      indications.level_detect <= (pwr == LTL_PWR_RUN) && line_s.signal_seen
                                  && !line_s.bit_sync;
      indications.sync_reached_ind <= (pwr == LTL_PWR_RUN) && line_s.bit_sync
                                      && !line_s.activated && !line_s.service_bit;
      indications.sync_reached_loop2_ind <= (pwr == LTL_PWR_RUN) && line_s.bit_sync
                                      && !line_s.activated && line_s.service_bit;
      indications.line_active_ind <= (pwr == LTL_PWR_RUN) && line_s.bit_sync
                                     && line_s.activated && !line_s.service_bit;
      indications.line_active_loop2_ind <= (pwr == LTL_PWR_RUN) && line_s.bit_sync
                                     && line_s.activated && line_s.service_bit;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[ST_SYNC_BIT]      = indications.sync_reached_ind;
    status_word[ST_ACTIVE_BIT]    = indications.line_active_ind;
    status_word[ST_SYNC_L2_BIT]   = indications.sync_reached_loop2_ind;
    status_word[ST_ACTIVE_L2_BIT] = indications.line_active_loop2_ind;
    status_word[ST_LEVEL_BIT]     = indications.level_detect;
    status_word[ST_DEACT_BIT]     = indications.deactivated;
  end

  ltl_serial_port u_port (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .cs_n              (cs_sync[1]),
    .sclk              (sclk_sync[1]),
    .mosi              (mosi_sync[1]),
    .status_in         (status_word),
    .miso              (spi_miso),
    .first_control_reg (ctrl_value),
    .ctrl_written      (ctrl_written)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      miso              <= 1'b0;
      first_control_reg <= CTRL_RESET;
    end else begin
      miso <= spi_miso;
      if (ctrl_written) begin
        first_control_reg <= ctrl_value;
      end
    end
  end

endmodule : ltl_layer1_control

// file: tb/ltl_l1c_asserts.sv
/* Checker for the layer-1 control top, seeing only its ports.
   Assumes one sys_clk domain; bound to every ltl_layer1_control. */
`timescale 1ns/10ps
module ltl_l1c_asserts
  import ltl_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 reset_pin_n,
  input wire ltl_line_t            line_in,
  input wire logic                 cs_n,
  input wire logic                 miso,
  input wire logic                 frame_sync,
  input wire logic                 device_reset,
  input wire ltl_ind_t             indications,
  input wire logic [REG_WIDTH-1:0] first_control_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Six cycles covers the two-flop input lag
  sequence held_s(logic [3:0] v);
    (line_in == v) [*6];
  endsequence
  // Line codes only mean something once the sequence has finished
  level_ind_a: assert property (held_s(4'h8) ##0 !indications.deactivated |->
    indications.level_detect)
    else $error("level detect not shown");
  sync_norm_a: assert property (held_s(4'hC) ##0 !indications.deactivated |->
    indications.sync_reached_ind && !indications.sync_reached_loop2_ind)
    else $error("normal sync indication wrong");
  sync_loop_a: assert property (held_s(4'hD) ##0 !indications.deactivated |->
    indications.sync_reached_loop2_ind && !indications.sync_reached_ind)
    else $error("loop2 sync indication wrong");
  active_loop_a: assert property (held_s(4'hF) ##0 !indications.deactivated |->
    indications.line_active_loop2_ind && !indications.line_active_ind)
    else $error("loop2 active indication wrong");
  pin_reset_a: assert property (!reset_pin_n [*5] |-> device_reset)
    else $error("pin reset not applied");
  miso_idle_a: assert property (cs_n [*8] |-> !miso)
    else $error("miso driven while deselected");
  ctrl_hold_a: assert property (cs_n [*8] |=> $stable(first_control_reg))
    else $error("control changed outside transfer");
  frame_gap_a: assert property (frame_sync |=> !frame_sync [*8])
    else $error("frame marker too close");
endmodule : ltl_l1c_asserts
bind ltl_layer1_control ltl_l1c_asserts ltl_l1c_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .reset_pin_n(reset_pin_n), .line_in(line_in), .cs_n(cs_n), .miso(miso),
  .frame_sync(frame_sync), .device_reset(device_reset), .indications(indications),
  .first_control_reg(first_control_reg));

// file: tb/ltl_host_model.sv
/* Host model on the serial control port: one byte each way per transfer.
   Assumes the bench clock; changes pins at its falling edge only. */
`timescale 1ns/10ps
module ltl_host_model (
  input  wire logic sys_clk,
  input  wire logic miso,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  // Phases of six cycles leave margin over the four-cycle port lag
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(negedge sys_clk) cs_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      repeat (6) @(negedge sys_clk);
      rx[i] = miso;
      sclk = 1'b1;
      repeat (6) @(negedge sys_clk);
    end
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    mosi = ~mosi; // No stale bit once released
    repeat (6) @(negedge sys_clk);
  endtask : xfer
endmodule : ltl_host_model

// file: tb/ltl_layer1_control_tb.sv
/* Self-checking bench for the layer-1 control top.
   Assumes the host model on the serial port and the bound checker. */
`timescale 1ns/10ps
module ltl_layer1_control_tb;
  import ltl_pkg::*;
  logic                 sys_clk = 1'b0;
  logic                 rst_n = 1'b0;
  ltl_mode_t            mode = LTL_MODE_ENDPOINT;
  logic                 reset_pin_n = 1'b1;
  logic                 restart_activation_cmd = 1'b0;
  logic                 crystal_clock_in = 1'b0;
  logic                 frame_clk_in = 1'b0;
  ltl_line_t            line_in = '0;
  logic                 cs_n, sclk, mosi, miso, line_bit_clk, aux_clk, frame_sync, device_reset;
  ltl_ind_t             indications;
  logic [REG_WIDTH-1:0] first_control_reg, rx;
  int failures = 0, total_checks = 0, frames = 0, xtal_n = 0, fclk_n = 0, div_n = 0;
  always #20 sys_clk = ~sys_clk;
  // Crystal 2.5 MHz and frame clock 3.125 MHz, both free running
  always @(negedge sys_clk) begin
    div_n <= div_n + 1;
    if (div_n % 5 == 4) crystal_clock_in <= ~crystal_clock_in;
    if (div_n % 4 == 3) frame_clk_in <= ~frame_clk_in;
  end
  always @(posedge crystal_clock_in) xtal_n++;
  always @(posedge frame_clk_in) fclk_n++;
  always @(posedge sys_clk) if (frame_sync === 1'b1) frames++;
  ltl_layer1_control ltl_layer1_control_i (.sys_clk(sys_clk), .rst_n(rst_n), .mode(mode),
    .reset_pin_n(reset_pin_n), .crystal_clock_in(crystal_clock_in), .frame_clk_in(frame_clk_in),
    .line_in(line_in), .restart_activation_cmd(restart_activation_cmd), .cs_n(cs_n),
    .sclk(sclk), .mosi(mosi),
    .miso(miso), .line_bit_clk(line_bit_clk), .aux_clk(aux_clk), .frame_sync(frame_sync),
    .device_reset(device_reset), .indications(indications),
    .first_control_reg(first_control_reg));
  ltl_host_model ltl_host_model_i (.sys_clk(sys_clk), .miso(miso), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  function automatic logic pick(input int sel);
    case (sel)
      0: return aux_clk;
      1: return line_bit_clk;
      2: return crystal_clock_in;
      default: return indications.deactivated;
    endcase
  endfunction : pick
  task automatic wait_rise(input int sel);
    logic p;
    p = pick(sel);
    for (int n = 0; n < 3000; n++) begin
      @(posedge sys_clk);
      #1;
      if (p === 1'b0 && pick(sel) === 1'b1) return;
      p = pick(sel);
    end
    failures++;
    test_done();
  endtask : wait_rise
  task automatic wait_frames(input int n);
    for (int k = 0; k < 3000; k++) begin
      @(negedge sys_clk);
      if (frames >= n) return;
    end
    failures++;
    test_done();
  endtask : wait_frames
  task automatic t_power();
    @(negedge sys_clk) reset_pin_n = 1'b0;
    repeat (45) wait_rise(2);
    check(device_reset, 1'b1);
    @(negedge sys_clk) reset_pin_n = 1'b1;
    repeat (10) wait_rise(2);
    // Design acts on the tenth rise two edges later; count frames from there
    repeat (3) @(negedge sys_clk);
    frames = 0;
    check(indications.deactivated, 1'b1);
    wait_frames(5);
    line_in = ltl_line_t'(4'h8);
    repeat (8) @(negedge sys_clk);
    check(indications.deactivated, 1'b1);
    wait_frames(6);
    repeat (4) @(negedge sys_clk);
    check(indications.deactivated, 1'b0);
    check(32'(frames), 6);
  endtask : t_power
  task automatic t_line();
    logic [3:0] in_v [5] = '{4'h8, 4'hC, 4'hD, 4'hE, 4'hF};
    logic [5:0] ex_v [5] = '{6'h02, 6'h20, 6'h08, 6'h10, 6'h04};
    for (int i = 0; i < 5; i++) begin
      @(negedge sys_clk) line_in = ltl_line_t'(in_v[i]);
      repeat (8) @(negedge sys_clk);
      check(indications, ex_v[i]);
    end
  endtask : t_line
  task automatic t_serial(input logic [3:0] ln, input logic [7:0] tx, input logic [7:0] st);
    @(negedge sys_clk) line_in = ltl_line_t'(ln);
    repeat (8) @(negedge sys_clk);
    ltl_host_model_i.xfer(tx, rx);
    check(rx, st);
    check(first_control_reg, tx);
  endtask : t_serial
  // Pin reset after power-up must skip the crystal sequence
  task automatic t_repin();
    @(negedge sys_clk) reset_pin_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(device_reset, 1'b1);
    check(indications.deactivated, 1'b1);
    @(negedge sys_clk) reset_pin_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    check(device_reset, 1'b0);
    check(indications.deactivated, 1'b0);
  endtask : t_repin
  task automatic t_restart();
    @(negedge sys_clk) line_in = '0;
    repeat (6) @(negedge sys_clk);
    check(indications.deactivated, 1'b0);
    restart_activation_cmd = 1'b1;
    @(negedge sys_clk) restart_activation_cmd = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(indications.deactivated, 1'b1);
    line_in = ltl_line_t'(4'h8);
    repeat (8) @(negedge sys_clk);
    check(indications.deactivated, 1'b0);
  endtask : t_restart
  // Interval between two output rises, counted in source clock rises
  task automatic period(input int sel, input ltl_mode_t m, input int exp);
    int a;
    @(negedge sys_clk) mode = m;
    wait_rise(sel);
    wait_rise(sel);
    a = (m == LTL_MODE_REPEATER) ? fclk_n : xtal_n;
    wait_rise(sel);
    check(32'(((m == LTL_MODE_REPEATER) ? fclk_n : xtal_n) - a), exp);
  endtask : period
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    check(first_control_reg, CTRL_RESET);
    t_power();
    t_line();
    t_serial(4'hC, 8'hA5, 8'h01);
    t_serial(4'hF, 8'h3C, 8'h08);
    t_repin();
    t_restart();
    period(0, LTL_MODE_ENDPOINT, 16);
    period(1, LTL_MODE_HDLC, 4);
    period(1, LTL_MODE_REPEATER, 4);
    test_done();
  end
endmodule : ltl_layer1_control_tb
